// ### bench/note_source_model.sv
// Partner model: note events and sample ticks for one voice
`timescale 1ns/100ps
`default_nettype none
module note_source_model #(
    parameter int TICK_DIV = 4 // Clock cycles per output sample
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Requests from the bench
    input wire logic on_req,
    input wire logic off_req,
    input wire logic tick_en,
    input wire logic [6:0] note,
    input wire logic [6:0] velocity,
    // Toward the voice
    output var voice_env_pkg::note_evt_t evt,
    output logic sample_tick
);
    int div; // Sample pacing counter
    // One-cycle event pulses and a paced sample tick
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt <= '0;
            sample_tick <= 1'b0;
            div <= 0;
        end else begin
            evt <= '{key_on: on_req, key_off: off_req, note: note, velocity: velocity};
            div <= (div >= TICK_DIV - 1) ? 0 : div + 1;
            sample_tick <= tick_en && (div == 0);
        end
    end
endmodule : note_source_model
`default_nettype wire

// ### bench/sample_voice_envelope_bench.sv
// Testbench: register table, envelope segments and level checks
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); end end
module sample_voice_envelope_bench;
    // Stimulus
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic on_req = 1'b0;
    logic off_req = 1'b0;
    logic tick_en = 1'b0;
    logic clk_en = 1'b1; // Freeze control
    logic [6:0] pitch_depth = 7'h00; // LFO pitch depth
    logic [6:0] note = 7'h40; // Played note
    logic [6:0] vel = 7'h7F; // Played velocity
    logic [15:0] g; // Gain snapshot
    voice_env_pkg::env_prog_t prog = '{hold_mode: 1'b0, first_rate: 6'h3F, rate2: 6'h3F,
        rate3: 6'h3F, rate4: 6'h00, release_rate: 6'h3F, key_rate_scaling: 4'h0,
        level2: 6'h20, level3: 6'h10, vel_sens: 4'h0, rate_vel_sw: 1'b0,
        amp_mod_sens: 4'h0, pitch_mod_sens: 3'h7, element_level: 7'h10};
    // Results
    voice_env_pkg::note_evt_t evt;
    logic sample_tick;
    logic [15:0] reg_rdata;
    logic [15:0] amp_gain;
    logic signed [11:0] pitch_offset;
    logic [2:0] env_state;
    logic env_active;
    int err_total = 0;
    int compares = 0;
    int n;
    logic [15:0] d;
    // Reset register contents: address, expected word
    typedef struct packed { logic [7:0] a; logic [15:0] d; } row_t;
    row_t rows [12] = '{'{8'h00, 16'h0000}, '{8'h01, 16'h0000}, '{8'h02, 16'h007F},
        '{8'h03, 16'h007F}, '{8'h04, 16'h0000}, '{8'h05, 16'h0000}, '{8'h06, 16'h0000},
        '{8'h07, 16'h0000}, '{8'h08, 16'h0000}, '{8'h0C, 16'h0000}, '{8'h10, 16'h0000},
        '{8'hFC, 16'h0000}};
    always #2 clk = ~clk;
    sample_voice_envelope i_sample_voice_envelope (.clk(clk), .resetn(resetn),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog(prog), .evt(evt),
        .sample_tick(sample_tick), .lfo_amplitude_depth(7'h00), .lfo_pitch_depth(pitch_depth),
        .lfo_wave(8'h40), .envelope_bias_control(7'h00), .amp_gain(amp_gain),
        .pitch_offset(pitch_offset), .env_state(env_state), .env_active(env_active));
    note_source_model #(.TICK_DIV(4)) i_note_source_model (.clk(clk), .resetn(resetn),
        .on_req(on_req), .off_req(off_req), .tick_en(tick_en), .note(note),
        .velocity(vel), .evt(evt), .sample_tick(sample_tick));
    // ----
    // Bus and event tasks
    // ----
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, w, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] r);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        r = reg_rdata;
    endtask : rd
    task automatic key(input logic on, input logic off);
        @(posedge clk);
        {on_req, off_req} <= {on, off};
        @(posedge clk);
        {on_req, off_req} <= 2'b00;
        @(posedge clk);
        #1;
    endtask : key
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 3000 && env_state !== s; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_st
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    // Watchdog against a hung sequence
    initial begin
        #60000;
        err_total++;
        $display("FAIL t=%0t watchdog expired", $time);
        summarize();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a, d);
            `CHK(d, rows[i].d)
        end
        wr(8'h01, 16'h0050);
        rd(8'h01, d);
        `CHK(d, 16'h0050)
        wr(8'h00, 16'h0060);
        rd(8'h00, d);
        `CHK(d, 16'h0000)
        wr(8'h02, 16'h0040);
        rd(8'h02, d);
        `CHK(d, 16'h007F)
        wr(8'h04, 16'h0080);
        rd(8'h04, d);
        `CHK(d[7:0], 8'h81)
        wr(8'h04, 16'h0000);
        // Attack start, fast segments, sustain on zero fourth rate
        key(1'b1, 1'b0);
        `CHK(env_state, voice_env_pkg::ST_ATTACK)
        rd(8'h08, d);
        `CHK(d, voice_env_pkg::LEVEL_ZERO)
        @(posedge clk);
        tick_en <= 1'b1;
        wait_st(voice_env_pkg::ST_SEG4);
        `CHK(env_state, voice_env_pkg::ST_SEG4)
        rd(8'h08, d);
        `CHK(d, 16'h4104)
        repeat (100) @(posedge clk);
        rd(8'h08, d);
        `CHK(d, 16'h4104)
        `CHK(amp_gain != 16'h0000, 1'b1)
        `CHK(pitch_offset, 12'h000)
        @(posedge clk);
        pitch_depth <= 7'h10;
        repeat (4) @(posedge clk);
        #1;
        `CHK(pitch_offset != 12'h000, 1'b1)
        @(posedge clk);
        pitch_depth <= 7'h00;
        for (int k = 4; k < 8; k++) wr(8'(k), 16'h0081);
        repeat (6) @(posedge clk);
        #1;
        `CHK(amp_gain, 16'h0000)
        // Release to silence, then a key-off while idle
        key(1'b0, 1'b1);
        `CHK(env_state, voice_env_pkg::ST_RELEASE)
        wait_st(voice_env_pkg::ST_IDLE);
        `CHK(env_active, 1'b0)
        key(1'b0, 1'b1);
        `CHK(env_state, voice_env_pkg::ST_IDLE)
        // Decaying fourth segment: restart, then release
        @(posedge clk);
        prog.rate4 <= 6'h01;
        key(1'b1, 1'b0);
        wait_st(voice_env_pkg::ST_SEG4);
        // Low enable freezes the gain, held at zero by the 0x81 offsets
        @(posedge clk);
        clk_en <= 1'b0;
        @(posedge clk);
        #1;
        g = amp_gain;
        repeat (40) @(posedge clk);
        #1;
        `CHK(amp_gain, g)
        @(posedge clk);
        clk_en <= 1'b1;
        key(1'b1, 1'b1);
        `CHK(env_state, voice_env_pkg::ST_ATTACK)
        wait_st(voice_env_pkg::ST_SEG4);
        key(1'b0, 1'b1);
        `CHK(env_state, voice_env_pkg::ST_RELEASE)
        wait_st(voice_env_pkg::ST_IDLE);
        `CHK(env_active, 1'b0)
        // Hold start: full level, time grows with the code
        for (int c = 1; c <= 2; c++) begin
            @(posedge clk);
            {prog.hold_mode, prog.first_rate, tick_en} <= {1'b1, 6'(c), 1'b0};
            key(1'b1, 1'b0);
            `CHK(env_state, voice_env_pkg::ST_HOLD)
            rd(8'h08, d);
            `CHK(d, voice_env_pkg::LEVEL_MAX)
            @(posedge clk);
            tick_en <= 1'b1;
            n = 0;
            for (int i = 0; i < 2000 && env_state === voice_env_pkg::ST_HOLD; i++) begin
                @(posedge clk);
                #1;
                if (sample_tick === 1'b1) n++;
            end
            `CHK((n >= 64 * c - 2) && (n <= 64 * c + 2), 1'b1)
            `CHK(env_state, voice_env_pkg::ST_SEG2)
            key(1'b0, 1'b1);
            wait_st(voice_env_pkg::ST_IDLE);
        end
        summarize();
    end
endmodule : sample_voice_envelope_bench
`default_nettype wire

// ### bench/sample_voice_envelope_monitor.sv
// Checker: port-level envelope properties of the voice amplitude path
`timescale 1ns/100ps
`default_nettype none
module sample_voice_envelope_monitor (
    // Clock and control
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Program, events, modulation
    input wire voice_env_pkg::env_prog_t prog,
    input wire voice_env_pkg::note_evt_t evt,
    input wire logic [6:0] lfo_pitch_depth,
    // Observed results
    input wire logic signed [11:0] pitch_offset,
    input wire logic [2:0] env_state,
    input wire logic env_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----
    // Events taken at an edge
    // ----
    logic go_on;  // Key-on accepted
    logic go_off; // Key-off alone accepted
    assign go_on = clk_en && evt.key_on;
    assign go_off = clk_en && evt.key_off && !evt.key_on;
    attack_start_a:
    assert property (go_on && !prog.hold_mode |=> env_state == voice_env_pkg::ST_ATTACK)
        else $error("attack start missing");
    hold_start_a:
    assert property (go_on && prog.hold_mode |=> env_state == voice_env_pkg::ST_HOLD)
        else $error("hold start missing");
    release_entry_a:
    assert property (go_off && env_active |=> env_state == voice_env_pkg::ST_RELEASE)
        else $error("release not entered");
    idle_off_a:
    assert property (go_off && !env_active |=> !env_active)
        else $error("key-off woke an idle voice");
    active_flag_a:
    assert property (env_active == (env_state != voice_env_pkg::ST_IDLE))
        else $error("active flag disagrees with state");
    attack_exit_a:
    assert property ($past(env_state) == voice_env_pkg::ST_ATTACK && env_state != $past(env_state)
        |-> env_state inside {voice_env_pkg::ST_SEG2, voice_env_pkg::ST_RELEASE,
        voice_env_pkg::ST_HOLD})
        else $error("attack left to a wrong segment");
    hold_exit_a:
    assert property ($past(env_state) == voice_env_pkg::ST_HOLD && env_state != $past(env_state)
        |-> env_state inside {voice_env_pkg::ST_SEG2, voice_env_pkg::ST_RELEASE,
        voice_env_pkg::ST_ATTACK})
        else $error("hold left to a wrong segment");
    sustain_hold_a:
    assert property (env_state == voice_env_pkg::ST_SEG4 && prog.rate4 == 6'h00 && !go_on
        && !go_off |=> env_state == voice_env_pkg::ST_SEG4)
        else $error("sustain left without a key event");
    pitch_quiet_a:
    assert property ((lfo_pitch_depth == 7'h00 || prog.pitch_mod_sens == 3'h0) [*4]
        |-> pitch_offset == 12'h000)
        else $error("pitch moved with no modulation");
    // Main scenarios reached
    cover property (env_state == voice_env_pkg::ST_SEG4 && prog.rate4 == 6'h00);
    cover property (go_off && env_state == voice_env_pkg::ST_SEG4);
    cover property (env_state == voice_env_pkg::ST_HOLD ##1 env_state == voice_env_pkg::ST_SEG2);
endmodule : sample_voice_envelope_monitor
bind sample_voice_envelope sample_voice_envelope_monitor i_sample_voice_envelope_monitor (
    .clk, .resetn, .clk_en, .prog, .evt, .lfo_pitch_depth, .pitch_offset, .env_state,
    .env_active);
`default_nettype wire

// ### core/sample_voice_envelope.sv
// Module: envelope, level scaling and modulation for one sample voice
`timescale 1ns/100ps
`default_nettype none
module sample_voice_envelope (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Program and events
    input wire voice_env_pkg::env_prog_t prog,
    input wire voice_env_pkg::note_evt_t evt,
    input wire logic sample_tick,
    // Modulation inputs
    input wire logic [6:0] lfo_amplitude_depth,
    input wire logic [6:0] lfo_pitch_depth,
    input wire logic signed [7:0] lfo_wave,
    input wire logic [6:0] envelope_bias_control,
    // Results
    output logic [15:0] amp_gain,
    output logic signed [11:0] pitch_offset,
    output logic [2:0] env_state,
    output logic env_active
);
    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        voice_env_pkg::env_state_t st;  // Envelope phase
        logic [15:0] level;             // Envelope level
        logic [11:0] hold_cnt;          // Hold ticks left
        logic [6:0] note;               // Latched note
        logic [6:0] vel;                // Latched velocity
        logic [27:0] bp_note;           // Break point notes, 4 x 7
        logic [31:0] bp_ofs;            // Break point offsets, 4 x 8
        logic [15:0] rdata;             // Read data
        logic [15:0] gain;              // Output gain
        logic signed [11:0] pitch;      // Output pitch shift
    } state_t;

    state_t cur; // Registered state
    state_t nxt; // Next state

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Rate table: step grows exponentially with rate code
    function automatic logic [15:0] rate_step(input logic [6:0] r);
        logic [15:0] base;
        base = {14'h0000, r[1:0]} + 16'h0004;
        if (r == 7'h00) begin
            rate_step = 16'h0000;
        end else if (r[6:0] >= 7'h3F) begin
            rate_step = voice_env_pkg::LEVEL_MAX;
        end else begin
            rate_step = base << r[5:2];
        end
    endfunction : rate_step

    // Key rate scaling and clamp to 1..63; rate code 0 stays 0
    function automatic logic [6:0] eff_rate(input logic [5:0] r, input logic [6:0] nt,
                                           input logic signed [3:0] ks);
        logic signed [9:0] adj;
        logic signed [9:0] sum;
        adj = 10'(($signed({3'b000, nt}) - $signed({3'b000, voice_env_pkg::RS_PIVOT}))
              * ks) >>> 5;
        sum = $signed({4'h0, r}) + adj;
        if (r == 6'h00) begin
            eff_rate = 7'h00;
        end else if (sum < 10'sh001) begin
            eff_rate = 7'h01;
        end else if (sum > 10'sh03F) begin
            eff_rate = 7'h3F;
        end else begin
            eff_rate = sum[6:0];
        end
    endfunction : eff_rate

    // Level code 0..63 to envelope scale
    function automatic logic [15:0] lvl16(input logic [5:0] l);
        lvl16 = {l, l, l[5:2]};
    endfunction : lvl16

    // Descent toward target, stopping on it
    function automatic logic [15:0] step_down(input logic [15:0] v, input logic [15:0] s,
                                             input logic [15:0] tgt);
        step_down = (v > tgt && v - tgt > s) ? v - s : tgt;
    endfunction : step_down

    // ------------------------------------------------------------
    // Break point offset at the latched note
    // ------------------------------------------------------------
    logic [6:0] bpn [voice_env_pkg::NUM_BP]; // Break point notes
    logic signed [7:0] bpo [voice_env_pkg::NUM_BP]; // Break point offsets
    genvar gi;
    generate
        for (gi = 0; gi < voice_env_pkg::NUM_BP; gi++) begin : g_bp
            assign bpn[gi] = cur.bp_note[gi*7 +: 7];
            assign bpo[gi] = cur.bp_ofs[gi*8 +: 8];
        end
    endgenerate

    logic signed [8:0] kbd_ofs; // Interpolated offset
    always_comb begin
        logic signed [17:0] num;
        logic [6:0] span;
        num = 18'sh00000;
        span = 7'h00;
        kbd_ofs = 9'(bpo[0]);
        if (cur.note >= bpn[3]) begin
            kbd_ofs = 9'(bpo[3]);
        end else begin
            for (int i = 2; i >= 0; i--) begin
                if (cur.note >= bpn[i] && cur.note < bpn[i+1]) begin
                    span = bpn[i+1] - bpn[i];
                    num = 18'($signed(9'(bpo[i+1]) - 9'(bpo[i]))
                          * $signed({11'h000, cur.note - bpn[i]}));
                    kbd_ofs = 9'(bpo[i]) + 9'(num / $signed({11'h000, span}));
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output level chain
    // ------------------------------------------------------------
    logic [6:0] scaled_level; // Clamped element level
    logic [13:0] vel_level; // Level after velocity
    logic [15:0] env_gain; // After envelope
    logic signed [11:0] next_pitch; // Pitch shift
    always_comb begin
        logic signed [9:0] sum;
        logic [10:0] vel_term;
        logic [9:0] am;
        logic [9:0] atten;
        vel_term = 11'h000;
        am = 10'h000;
        sum = 10'(cur.bp_ofs == 32'h0 ? 9'sh000 : kbd_ofs)
              + $signed({3'b000, prog.element_level});
        if (sum < 10'sh000) begin
            scaled_level = 7'h00;
        end else if (sum > $signed({3'b000, voice_env_pkg::OUT_MAX})) begin
            scaled_level = voice_env_pkg::OUT_MAX;
        end else begin
            scaled_level = sum[6:0];
        end
        // Velocity sensitivity: reduce by sens x distance from best case
        if (prog.vel_sens[3]) begin
            vel_term = 11'(cur.vel * 7'(-prog.vel_sens)) >> 3;
        end else begin
            vel_term = 11'((7'h7F - cur.vel) * 7'(prog.vel_sens)) >> 3;
        end
        vel_level = {scaled_level, 7'h00} - ((vel_term > 11'({scaled_level, 3'b000}))
                    ? 14'({scaled_level, 7'h00}) : 14'({vel_term, 3'b000}));
        // Amplitude modulation or bias attenuation
        if (prog.amp_mod_sens[3]) begin
            am = 10'(envelope_bias_control * 7'(-prog.amp_mod_sens)) >> 3;
        end else begin
            am = 10'((lfo_amplitude_depth * 7'(prog.amp_mod_sens)) >> 3)
                 * 10'(lfo_wave[7] ? 8'(-lfo_wave) : 8'(lfo_wave)) >> 7;
        end
        atten = (am > 10'h07F) ? 10'h07F : am;
        // Product needs 37 bits; the shift keeps full scale inside 16 bits
        env_gain = 16'((48'(cur.level) * 48'(vel_level) * 48'(7'h7F - atten[6:0])) >> 21);
        next_pitch = 12'((lfo_pitch_depth * prog.pitch_mod_sens) * lfo_wave >>> 7);
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [6:0] r1;
        logic [15:0] s;
        logic [1:0] idx;
        logic signed [8:0] vdelta;
        nxt = cur;
        r1 = 7'h00;
        s = 16'h0000;
        idx = reg_addr[1:0];
        vdelta = 9'sh000;
        nxt.gain = env_gain;
        nxt.pitch = next_pitch;
        // Register writes
        if (reg_wr) begin
            if (reg_addr[7:2] == voice_env_pkg::CTL_BP_BASE[7:2]) begin
                if ((idx == 2'd0 || reg_wdata[6:0] >= bpn[idx - 2'd1])
                    && (idx == 2'd3 || reg_wdata[6:0] <= bpn[idx + 2'd1])) begin
                    nxt.bp_note[idx*7 +: 7] = reg_wdata[6:0];
                end
            end else if (reg_addr[7:2] == voice_env_pkg::CTL_BP_OFS_BASE[7:2]) begin
                nxt.bp_ofs[idx*8 +: 8] = (reg_wdata[7:0] == 8'h80) ? 8'h81
                                         : reg_wdata[7:0];
            end
        end
        // Register reads: notes, offsets, live state
        nxt.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr[7:2])
                6'h00: nxt.rdata = {9'h000, bpn[idx]};
                6'h01: nxt.rdata = {{8{bpo[idx][7]}}, bpo[idx]};
                6'h02: nxt.rdata = cur.level;
                6'h03: nxt.rdata = {13'h0000, cur.st};
                default: nxt.rdata = 16'h0000;
            endcase
        end
        // First rate adjusted by velocity
        vdelta = 9'(($signed({2'b00, 7'h7F - cur.vel}) * prog.vel_sens) >>> 5);
        if (prog.rate_vel_sw && prog.vel_sens != 4'sh0) begin
            r1 = 7'(($signed({3'b000, prog.first_rate}) - vdelta) < 9'sh001 ? 9'sh001
                 : ($signed({3'b000, prog.first_rate}) - vdelta) > 9'sh03F ? 9'sh03F
                 : $signed({3'b000, prog.first_rate}) - vdelta);
        end else begin
            r1 = {1'b0, prog.first_rate};
        end
        // Envelope
        if (evt.key_on) begin
            nxt.note = evt.note;
            nxt.vel = evt.velocity;
            if (prog.hold_mode) begin
                nxt.st = voice_env_pkg::ST_HOLD;
                nxt.level = voice_env_pkg::LEVEL_MAX;
                nxt.hold_cnt = 12'({prog.first_rate, 6'h00});
            end else begin
                nxt.st = voice_env_pkg::ST_ATTACK;
                nxt.level = voice_env_pkg::LEVEL_ZERO;
            end
        end else if (evt.key_off && cur.st != voice_env_pkg::ST_IDLE) begin
            nxt.st = voice_env_pkg::ST_RELEASE;
        end else if (sample_tick) begin
            case (cur.st)
                voice_env_pkg::ST_ATTACK: begin
                    s = rate_step(eff_rate(r1[5:0], cur.note, prog.key_rate_scaling));
                    if (voice_env_pkg::LEVEL_MAX - cur.level <= s) begin
                        nxt.level = voice_env_pkg::LEVEL_MAX;
                        nxt.st = voice_env_pkg::ST_SEG2;
                    end else begin
                        nxt.level = cur.level + s;
                    end
                end
                voice_env_pkg::ST_HOLD: begin
                    if (cur.hold_cnt == 12'h000) begin
                        nxt.st = voice_env_pkg::ST_SEG2;
                    end else begin
                        nxt.hold_cnt = cur.hold_cnt - 12'h001;
                    end
                end
                voice_env_pkg::ST_SEG2: begin
                    s = rate_step(eff_rate(prog.rate2, cur.note, prog.key_rate_scaling));
                    nxt.level = step_down(cur.level, s, lvl16(prog.level2));
                    if (nxt.level == lvl16(prog.level2)) begin
                        nxt.st = voice_env_pkg::ST_SEG3;
                    end
                end
                voice_env_pkg::ST_SEG3: begin
                    s = rate_step(eff_rate(prog.rate3, cur.note, prog.key_rate_scaling));
                    if (lvl16(prog.level3) >= cur.level) begin
                        nxt.level = (lvl16(prog.level3) - cur.level > s) ? cur.level + s
                                    : lvl16(prog.level3);
                    end else begin
                        nxt.level = step_down(cur.level, s, lvl16(prog.level3));
                    end
                    if (nxt.level == lvl16(prog.level3)) begin
                        nxt.st = voice_env_pkg::ST_SEG4;
                    end
                end
                voice_env_pkg::ST_SEG4: begin
                    s = rate_step(eff_rate(prog.rate4, cur.note, prog.key_rate_scaling));
                    nxt.level = step_down(cur.level, s, voice_env_pkg::LEVEL_ZERO);
                end
                voice_env_pkg::ST_RELEASE: begin
                    s = rate_step(eff_rate(prog.release_rate, cur.note,
                                           prog.key_rate_scaling));
                    nxt.level = step_down(cur.level, s, voice_env_pkg::LEVEL_ZERO);
                    if (nxt.level == voice_env_pkg::LEVEL_ZERO) begin
                        nxt.st = voice_env_pkg::ST_IDLE;
                    end
                end
                default: begin
                    nxt.level = voice_env_pkg::LEVEL_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= '{st: voice_env_pkg::ST_IDLE, level: 16'h0000, hold_cnt: 12'h000,
                     note: 7'h00, vel: 7'h00, bp_note: {7'h7F, 7'h7F, 7'h00, 7'h00},
                     bp_ofs: 32'h00000000, rdata: 16'h0000, gain: 16'h0000,
                     pitch: 12'sh000};
        end else if (clk_en) begin
            cur <= nxt;
        end
    end

    // Outputs straight from flip-flops, except env_active, decoded from the state
    assign reg_rdata = cur.rdata;
    assign amp_gain = cur.gain;
    assign pitch_offset = cur.pitch;
    assign env_state = cur.st;
    assign env_active = (cur.st != voice_env_pkg::ST_IDLE);
endmodule : sample_voice_envelope
`default_nettype wire

// ### core/voice_env_pkg.sv
// Package: constants and carriers for the per-voice amplitude path
package voice_env_pkg;
    // -------------------------------------------------------------
    // Widths and ranges
    // -------------------------------------------------------------
    localparam int unsigned LEVEL_W = 16;             // Envelope accumulator width
    localparam logic [15:0] LEVEL_MAX = 16'hFFFF;     // Full envelope level
    localparam logic [15:0] LEVEL_ZERO = 16'h0000;    // Silent level
    localparam logic [5:0] RATE_MAX = 6'h3F;          // Top rate code
    localparam logic [6:0] NOTE_MAX = 7'h7F;          // Highest note number
    localparam logic [6:0] OUT_MAX = 7'h7F;           // Highest scaled element level
    localparam int unsigned NUM_BP = 4;               // Break point count
    localparam int unsigned HOLD_SHIFT = 6;           // Hold ticks per hold code step, log2
    localparam logic [6:0] RS_PIVOT = 7'h40;          // Note at which rate scaling is neutral
    localparam logic [7:0] CTL_BP_BASE = 8'h00;       // Break point note slot base
    localparam logic [7:0] CTL_BP_OFS_BASE = 8'h04;   // Break point offset slot base

    // -------------------------------------------------------------
    // Envelope states
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ATTACK = 3'b001,
        ST_HOLD = 3'b010,
        ST_SEG2 = 3'b011,
        ST_SEG3 = 3'b100,
        ST_SEG4 = 3'b101,
        ST_RELEASE = 3'b110
    } env_state_t;

    // -------------------------------------------------------------
    // Per-element program
    // -------------------------------------------------------------
    typedef struct packed {
        logic hold_mode;              // 1 = hold start, 0 = attack start
        logic [5:0] first_rate;       // Hold interval or first rate
        logic [5:0] rate2;            // Segment 2 rate
        logic [5:0] rate3;            // Segment 3 rate
        logic [5:0] rate4;            // Segment 4 rate
        logic [5:0] release_rate;     // Release rate
        logic signed [3:0] key_rate_scaling; // -7..+7
        logic [5:0] level2;           // Segment 2 target
        logic [5:0] level3;           // Segment 3 target
        logic signed [3:0] vel_sens;  // -7..+7
        logic rate_vel_sw;            // Velocity steers first rate
        logic signed [3:0] amp_mod_sens; // -7..+7
        logic [2:0] pitch_mod_sens;   // 0..7
        logic [6:0] element_level;    // Base element level
    } env_prog_t;

    // Note event from note assignment
    typedef struct packed {
        logic key_on;                 // Key-on pulse
        logic key_off;                // Key-off pulse
        logic [6:0] note;             // Note number
        logic [6:0] velocity;         // Key velocity
    } note_evt_t;
endpackage : voice_env_pkg
